//--- include/ssm_pkg.sv
package ssm_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int DIV_W  = 16;

    // register map, one byte per address
    localparam logic [ADDR_W-1:0] ADDR_RXSC  = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_RXBUF = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_TXSC  = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_BAUDC = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_DIVH  = 3'h4;
    localparam logic [ADDR_W-1:0] ADDR_DIVL  = 3'h5;
    localparam logic [ADDR_W-1:0] ADDR_TXBUF = 3'h6;
    localparam logic [ADDR_W-1:0] ADDR_INTC  = 3'h7;

    // receive_status_control fields
    localparam int RXSC_PORT_ON = 7;
    localparam int RXSC_NINE    = 6;
    localparam int RXSC_ONCE    = 5;
    localparam int RXSC_CONT    = 4;
    localparam int RXSC_FRAME   = 2;
    localparam int RXSC_OVER    = 1;
    localparam int RXSC_NINTH   = 0;
    // transmit_status_control fields
    localparam int TXSC_MASTER = 7;
    localparam int TXSC_NINE   = 6;
    localparam int TXSC_ENABLE = 5;
    localparam int TXSC_SYNC   = 4;
    localparam int TXSC_EMPTY  = 1;
    localparam int TXSC_NINTH  = 0;
    // baud_control fields
    localparam int BAUDC_CKP  = 4;
    localparam int BAUDC_WIDE = 3;
    // interrupt control fields
    localparam int INTC_RCIE = 3;
    localparam int INTC_TXIE = 2;
    localparam int INTC_RCIF = 1;
    localparam int INTC_TXIF = 0;

    localparam logic [DATA_W-1:0] BYTE_ZERO  = 8'h00;
    localparam logic [DIV_W-1:0]  DIV_ZERO   = 16'h0000;
    localparam logic [DIV_W-1:0]  DIV_ONE    = 16'h0001;
    localparam logic [3:0]        BITS_8     = 4'h8;
    localparam logic [3:0]        BITS_9     = 4'h9;
    localparam logic [3:0]        CNT_ZERO   = 4'h0;
    localparam logic [3:0]        CNT_ONE    = 4'h1;

    typedef enum logic [0:0] {SSM_RX_IDLE, SSM_RX_SHIFT} ssm_rx_e;
endpackage

//--- include/ssm_baud_if.sv
`timescale 1ns/1ns
interface ssm_baud_if;
    logic [7:0] div_hi;
    logic [7:0] div_lo;
    logic       wide;
    logic       run;
    logic       tick;
    modport ctl (output div_hi, output div_lo, output wide, output run,
                 input tick);
    modport gen (input div_hi, input div_lo, input wide, input run,
                 output tick);
endinterface

//--- rtl/ssm_baud.sv
`timescale 1ns/1ns
module ssm_baud
(
    input wire logic clk,
    input wire logic resetn,
    ssm_baud_if.gen  bif
);
    import ssm_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } ssm_baud_s;

    ssm_baud_s        s_r;
    ssm_baud_s        s_nxt;
    logic [DIV_W-1:0] div;

    // one tick every divisor+1 clocks; each tick is half a shift clock
    always_comb
    begin
        div = bif.wide ? {bif.div_hi, bif.div_lo} : {BYTE_ZERO, bif.div_lo};
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!bif.run)
        begin
            s_nxt.cnt = div;
        end
        else if (s_r.cnt == DIV_ZERO)
        begin
            s_nxt.cnt = div;
            s_nxt.tick = 1'b1;
        end
        else
        begin
            s_nxt.cnt = s_r.cnt - DIV_ONE;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign bif.tick = s_r.tick;
endmodule

//--- rtl/ssm_top.sv
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Overview of operation
// - either receive enable starts reception once synchronous master mode is set and no overrun is pending
// - master reception samples data on the shift clock trailing edge: falling when idle low, rising when idle high
// - single receive enable alone takes exactly one word, then stops
// - continuous enable receives words back to back until cleared or stopped by an overrun
// - both enables set: continuous reception wins
// - receive flag set on word complete; request only if enabled
// - ninth bit and error flags readable in receive status
// - reading the receive buffer returns the received word
// - clearing continuous enable clears pending receive errors
// - master clock source cleared: slave, uses external shift clock
// - slave keeps shifting on the external clock during low power
// - first of two buffered words moves to shift register at once
// - second word stays buffered; buffer-empty flag stays clear
// - after first word shifts out, second loads, then empty flag sets
// - enabled transmit request wakes the processor from sleep
// - writing the transmit buffer starts transmission when enabled
// - buffer-empty flag not software clearable; cleared by buffer write
// - shift-register-empty bit read-only, set when shift register empty
// - idle polarity bit: set idles clock high, cleared idles low
module ssm_top
(
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic [ssm_pkg::ADDR_W-1:0] addr,
    input  wire logic [ssm_pkg::DATA_W-1:0] wr_data,
    input  wire logic                       wr_en,
    input  wire logic                       rd_en,
    output wire logic [ssm_pkg::DATA_W-1:0] rd_data,
    input  wire logic                       low_power,
    input  wire logic                       shift_clock_pin,
    output wire logic                       shift_clock_val,
    output wire logic                       shift_clock_oe,
    input  wire logic                       serial_data_pin,
    output wire logic                       serial_data_val,
    output wire logic                       serial_data_oe,
    output wire logic                       rx_irq,
    output wire logic                       tx_irq
);
    import ssm_pkg::*;

    typedef struct packed {
        logic              port_on;
        logic              rx_nine;
        logic              rx_once;
        logic              rx_cont;
        logic              frame_err;
        logic              over_err;
        logic              rx_ninth;
        logic [DATA_W-1:0] rxbuf;
        logic              master;
        logic              tx_nine;
        logic              tx_enable;
        logic              sync;
        logic              tx_ninth;
        logic              ckp;
        logic              wide;
        logic [DATA_W-1:0] divh;
        logic [DATA_W-1:0] divl;
        logic              rcie;
        logic              txie;
        logic              rcif;
        logic [DATA_W-1:0] txbuf;
        logic              txbuf_ninth;
        logic              txbuf_full;
        logic [8:0]        shreg;
        logic              shreg_full;
        logic [3:0]        tx_left;
        ssm_rx_e           rx_st;
        logic [8:0]        rsr;
        logic [3:0]        rx_cnt;
        logic              ck_int;
        logic              ck_m1;
        logic              ck_m2;
        logic              ck_prev;
        logic              dt_m1;
        logic              dt_m2;
        logic [DATA_W-1:0] rdata;
    } ssm_state_s;

    ssm_state_s s_r;
    ssm_state_s s_nxt;
    ssm_baud_if bif ();
    logic       mst_cfg;
    logic       tx_on;
    logic       rx_idle;
    logic       rx_start;
    logic       rx_fall;
    logic       rx_last;
    logic [3:0] rx_bits;
    logic [8:0] rsr_in;
    logic       rxbuf_read;
    logic       ext_fall;
    logic       tx_fall;
    logic       tx_done;
    logic       tx_load;
    logic       txif;

    ssm_baud u_baud
    (
        .clk    (clk),
        .resetn (resetn),
        .bif    (bif)
    );
    assign bif.div_hi = s_r.divh;
    assign bif.div_lo = s_r.divl;
    assign bif.wide   = s_r.wide;
    // master clock halts in low power; slave clock comes from the peer
    assign bif.run    = (s_r.rx_st == SSM_RX_SHIFT) && !low_power;

    assign mst_cfg    = s_r.port_on && s_r.sync && s_r.master;
    assign tx_on      = s_r.port_on && s_r.sync && !s_r.master
                        && s_r.tx_enable;
    assign rx_idle    = (s_r.rx_st == SSM_RX_IDLE);
    assign rx_start   = rx_idle && mst_cfg && (s_r.rx_once || s_r.rx_cont)
                        && !s_r.over_err
                        && !s_r.shreg_full;
    assign rx_bits    = s_r.rx_nine ? BITS_9 : BITS_8;
    // a falling edge of the internal clock is a tick while it is high
    assign rx_fall    = !rx_idle && bif.tick && s_r.ck_int;
    assign rx_last    = rx_fall && (s_r.rx_cnt == rx_bits - CNT_ONE);
    assign rsr_in     = {s_r.dt_m2, s_r.rsr[8:1]};
    assign rxbuf_read = rd_en && (addr == ADDR_RXBUF);
    assign ext_fall   = (s_r.ck_prev ^ s_r.ckp) && !(s_r.ck_m2 ^ s_r.ckp);
    assign tx_fall    = tx_on && s_r.shreg_full && ext_fall;
    assign tx_done    = tx_fall && (s_r.tx_left == CNT_ONE);
    assign tx_load    = tx_on && rx_idle && s_r.txbuf_full
                        && !s_r.shreg_full;
    assign txif       = !s_r.txbuf_full;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ck_m1   = shift_clock_pin;
        s_nxt.ck_m2   = s_r.ck_m1;
        s_nxt.ck_prev = s_r.ck_m2;
        s_nxt.dt_m1   = serial_data_pin;
        s_nxt.dt_m2   = s_r.dt_m1;
        s_nxt.rdata   = BYTE_ZERO;

        // slave transmit shifter, clocked by the peer's falling edges, or rising edges when the idle polarity bit is set
        if (!tx_on)
        begin
            s_nxt.shreg_full = 1'b0;
            s_nxt.tx_left    = CNT_ZERO;
        end
        else if (tx_fall)
        begin
            s_nxt.shreg   = s_r.shreg >> 1;
            s_nxt.tx_left = s_r.tx_left - CNT_ONE;
            if (tx_done)
                s_nxt.shreg_full = 1'b0;
        end
        if (tx_load)
        begin
            // the buffer keeps a second word until the shifter drains
            s_nxt.shreg      = {s_r.txbuf_ninth, s_r.txbuf};
            s_nxt.tx_left    = s_r.tx_nine ? BITS_9 : BITS_8;
            s_nxt.shreg_full = 1'b1;
            s_nxt.txbuf_full = 1'b0;
        end

        if (wr_en)
        begin
            case (addr)
                ADDR_RXSC:
                begin
                    s_nxt.port_on = wr_data[RXSC_PORT_ON];
                    s_nxt.rx_nine = wr_data[RXSC_NINE];
                    s_nxt.rx_once = wr_data[RXSC_ONCE];
                    s_nxt.rx_cont = wr_data[RXSC_CONT];
                    if (!wr_data[RXSC_CONT])
                    begin
                        s_nxt.frame_err = 1'b0;
                        s_nxt.over_err  = 1'b0;
                    end
                end
                ADDR_TXSC:
                begin
                    s_nxt.master    = wr_data[TXSC_MASTER];
                    s_nxt.tx_nine   = wr_data[TXSC_NINE];
                    s_nxt.tx_enable = wr_data[TXSC_ENABLE];
                    s_nxt.sync      = wr_data[TXSC_SYNC];
                    s_nxt.tx_ninth  = wr_data[TXSC_NINTH];
                end
                ADDR_BAUDC:
                begin
                    s_nxt.ckp  = wr_data[BAUDC_CKP];
                    s_nxt.wide = wr_data[BAUDC_WIDE];
                end
                ADDR_DIVH:  s_nxt.divh = wr_data;
                ADDR_DIVL:  s_nxt.divl = wr_data;
                ADDR_TXBUF:
                begin
                    s_nxt.txbuf       = wr_data;
                    s_nxt.txbuf_ninth = s_r.tx_ninth;
                    s_nxt.txbuf_full  = 1'b1;
                end
                ADDR_INTC:
                begin
                    s_nxt.rcie = wr_data[INTC_RCIE];
                    s_nxt.txie = wr_data[INTC_TXIE];
                end
                default: ;
            endcase
        end

        if (rd_en)
        begin
            case (addr)
                ADDR_RXSC:
                begin
                    s_nxt.rdata[RXSC_PORT_ON] = s_r.port_on;
                    s_nxt.rdata[RXSC_NINE]    = s_r.rx_nine;
                    s_nxt.rdata[RXSC_ONCE]    = s_r.rx_once;
                    s_nxt.rdata[RXSC_CONT]    = s_r.rx_cont;
                    s_nxt.rdata[RXSC_FRAME]   = s_r.frame_err;
                    s_nxt.rdata[RXSC_OVER]    = s_r.over_err;
                    s_nxt.rdata[RXSC_NINTH]   = s_r.rx_ninth;
                end
                ADDR_RXBUF: s_nxt.rdata = s_r.rxbuf;
                ADDR_TXSC:
                begin
                    s_nxt.rdata[TXSC_MASTER] = s_r.master;
                    s_nxt.rdata[TXSC_NINE]   = s_r.tx_nine;
                    s_nxt.rdata[TXSC_ENABLE] = s_r.tx_enable;
                    s_nxt.rdata[TXSC_SYNC]   = s_r.sync;
                    s_nxt.rdata[TXSC_EMPTY]  = !s_r.shreg_full;
                    s_nxt.rdata[TXSC_NINTH]  = s_r.tx_ninth;
                end
                ADDR_BAUDC:
                begin
                    s_nxt.rdata[BAUDC_CKP]  = s_r.ckp;
                    s_nxt.rdata[BAUDC_WIDE] = s_r.wide;
                end
                ADDR_DIVH:  s_nxt.rdata = s_r.divh;
                ADDR_DIVL:  s_nxt.rdata = s_r.divl;
                ADDR_TXBUF: s_nxt.rdata = s_r.txbuf;
                ADDR_INTC:
                begin
                    s_nxt.rdata[INTC_RCIE] = s_r.rcie;
                    s_nxt.rdata[INTC_TXIE] = s_r.txie;
                    s_nxt.rdata[INTC_RCIF] = s_r.rcif;
                    s_nxt.rdata[INTC_TXIF] = txif;
                end
                default: s_nxt.rdata = BYTE_ZERO;
            endcase
            if (rxbuf_read)
                s_nxt.rcif = 1'b0;
        end

        // master receiver; completion below overrides the read clear
        case (s_r.rx_st)
            SSM_RX_IDLE:
            begin
                s_nxt.ck_int = 1'b0;
                s_nxt.rx_cnt = CNT_ZERO;
                if (rx_start)
                    s_nxt.rx_st = SSM_RX_SHIFT;
            end
            SSM_RX_SHIFT:
            begin
                if (!mst_cfg || !(s_r.rx_once || s_r.rx_cont))
                begin
                    s_nxt.rx_st  = SSM_RX_IDLE;
                    s_nxt.ck_int = 1'b0;
                end
                else if (bif.tick)
                begin
                    s_nxt.ck_int = !s_r.ck_int;
                    if (rx_fall)
                    begin
                        s_nxt.rsr    = rsr_in;
                        s_nxt.rx_cnt = s_r.rx_cnt + CNT_ONE;
                    end
                    if (rx_last)
                    begin
                        s_nxt.rx_cnt = CNT_ZERO;
                        if (s_r.rcif && !rxbuf_read)
                            s_nxt.over_err = 1'b1;
                        else
                        begin
                            s_nxt.rxbuf    = s_r.rx_nine ? rsr_in[7:0]
                                                         : rsr_in[8:1];
                            s_nxt.rx_ninth = s_r.rx_nine && rsr_in[8];
                            s_nxt.rcif     = 1'b1;
                        end
                        if (!s_r.rx_cont)
                        begin
                            s_nxt.rx_once = 1'b0;
                            s_nxt.rx_st   = SSM_RX_IDLE;
                        end
                        else if (s_r.rcif && !rxbuf_read)
                            s_nxt.rx_st = SSM_RX_IDLE;
                        // otherwise stay
                    end
                end
            end
            default:
            begin
                s_nxt.rx_st  = SSM_RX_IDLE;
                s_nxt.ck_int = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign rd_data         = s_r.rdata;
    assign shift_clock_val = s_r.ck_int ^ s_r.ckp;
    assign shift_clock_oe  = mst_cfg;
    assign serial_data_val = s_r.shreg[0];
    assign serial_data_oe  = tx_on && rx_idle;
    assign rx_irq          = s_r.rcif && s_r.rcie;
    assign tx_irq          = txif && s_r.txie;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_rx_start_enable: assert property (
        rx_start |=> s_r.rx_st == SSM_RX_SHIFT)
        else $error("reception did not start on enable");
    a_rx_sample_fall: assert property (
        rx_fall |=> s_r.rsr[8] == $past(s_r.dt_m2))
        else $error("data not sampled at falling edge");
    a_single_word_stop: assert property (
        rx_last && !s_r.rx_cont |=> !s_r.rx_once && rx_idle)
        else $error("single reception did not stop");
    a_cont_keeps_going: assert property (
        rx_last && s_r.rx_cont && !s_r.rcif && !(wr_en && addr == ADDR_RXSC)
        |=> !rx_idle ##1 (!rx_idle || $past(wr_en)))
        else $error("continuous reception stopped");
    a_rx_flag_irq: assert property (
        rx_last && !s_r.rcif |=> s_r.rcif && rx_irq == s_r.rcie)
        else $error("receive flag or request wrong");
    a_rxbuf_read_data: assert property (
        rxbuf_read |=> rd_data == $past(s_r.rxbuf))
        else $error("receive buffer read wrong");
    a_cont_clears_err: assert property (
        wr_en && addr == ADDR_RXSC && !wr_data[RXSC_CONT]
        && !(rx_last && s_r.rcif) |=> !s_r.over_err && !s_r.frame_err)
        else $error("errors not cleared");
    a_slave_no_clock: assert property (
        !mst_cfg |=> rx_idle && !s_r.ck_int)
        else $error("slave runs its own clock");
    a_shift_in_sleep: assert property (
        low_power && tx_fall && !tx_done
        |=> s_r.shreg == ($past(s_r.shreg) >> 1))
        else $error("slave shift halted");
    a_txif_after_load: assert property (
        $rose(txif) |-> $past(tx_load))
        else $error("empty flag set without load");
    a_half_duplex: assert property (
        !rx_idle |=> !$rose(s_r.shreg_full))
        else $error("transmit during reception");
    c_single_word: cover property (rx_last && !s_r.rx_cont);
    c_two_words: cover property (rx_last && s_r.rx_cont ##[1:400] rx_last);
    c_slave_word: cover property (tx_done && low_power);
    c_overrun: cover property ($rose(s_r.over_err));
endmodule

//--- verif/ssm_peer.sv
`timescale 1ns/1ns
module ssm_peer
(
    input  wire logic dev_ck,
    input  wire logic dev_ck_oe,
    input  wire logic dev_dt,
    output logic      ck_drv,
    output logic      dt_drv
);
    logic [15:0] pat;
    logic [7:0]  got;
    initial
    begin
        pat    = 16'h0000;
        got    = 8'h00;
        ck_drv = 1'b0;
    end
    // next bit goes out after each master clock fall, device samples the fall
    always @(negedge dev_ck)
        if (dev_ck_oe)
            pat = {~pat[0], pat[15:1]};
    assign dt_drv = pat[0];
    // slave clock idles low between frames; data taken on each fall
    task automatic frame(input int n);
        repeat (n)
        begin
            #400 ck_drv = 1'b1;
            #400 ck_drv = 1'b0;
            got = {dev_dt, got[7:1]};
        end
    endtask
endmodule

//--- verif/tb_sync_serial_master_rx_slave_tx.sv
`timescale 1ns/1ns
module tb_sync_serial_master_rx_slave_tx;
    import ssm_pkg::*;
    logic              clk;
    logic              resetn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rd_data;
    logic              low_power;
    logic              ck_pin_out;
    logic              ck_pin_oe;
    logic              dt_pin_out;
    logic              dt_pin_oe;
    logic              rx_irq;
    logic              tx_irq;
    logic              peer_ck;
    logic              peer_dt;
    wire               ck_line = ck_pin_oe ? ck_pin_out : peer_ck;
    wire               dt_line = dt_pin_oe ? dt_pin_out : peer_dt;
    int                error_cnt;
    int                total_checks;
    logic [7:0]        rv;

    ssm_top dut_u
    (
        .clk             (clk),
        .resetn          (resetn),
        .addr            (addr),
        .wr_data         (wr_data),
        .wr_en           (wr_en),
        .rd_en           (rd_en),
        .rd_data         (rd_data),
        .low_power       (low_power),
        .shift_clock_pin (ck_line),
        .shift_clock_val (ck_pin_out),
        .shift_clock_oe  (ck_pin_oe),
        .serial_data_pin (dt_line),
        .serial_data_val (dt_pin_out),
        .serial_data_oe  (dt_pin_oe),
        .rx_irq          (rx_irq),
        .tx_irq          (tx_irq)
    );
    ssm_peer peer_u
    (
        .dev_ck    (ck_line),
        .dev_ck_oe (ck_pin_oe),
        .dev_dt    (dt_line),
        .ck_drv    (peer_ck),
        .dt_drv    (peer_dt)
    );

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 rv = rd_data;
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        rd(a);
        chk(rv, exp);
    endtask
    // poll a register until any bit of the mask shows up
    task automatic wait_bit(input logic [2:0] a, input logic [7:0] m);
        int n;
        n = 0;
        rd(a);
        while ((rv & m) == 8'h00 && n < 200)
        begin
            rd(a);
            n++;
        end
        chk(rv & m, m);
    endtask

    task automatic t_reset();
        rchk(ADDR_RXSC, 8'h00);
        rchk(ADDR_TXSC, 8'h02);
        rchk(ADDR_INTC, 8'h01);
        wr(ADDR_TXSC, 8'h90);
        wr(ADDR_RXSC, 8'h80);
        wr(ADDR_BAUDC, 8'h10);
        @(posedge clk);
        #1 chk({7'h00, ck_pin_out}, 8'h01);
        chk({7'h00, ck_pin_oe}, 8'h01);
        wr(ADDR_BAUDC, 8'h00);
        @(posedge clk);
        #1 chk({7'h00, ck_pin_out}, 8'h00);
    endtask
    task automatic t_single();
        int hi;
        hi = 0;
        wr(ADDR_DIVL, 8'h03);
        wr(ADDR_INTC, 8'h08);
        peer_u.pat = 16'h015A;
        wr(ADDR_RXSC, 8'hE0);
        repeat (6) @(posedge clk);
        #1 chk({7'h00, dt_pin_oe}, 8'h00);
        wait_bit(ADDR_INTC, 8'h02);
        chk({7'h00, rx_irq}, 8'h01);
        rchk(ADDR_RXSC, 8'hC1);
        rchk(ADDR_RXBUF, 8'h5A);
        chk({7'h00, rx_irq}, 8'h00);
        repeat (64)
        begin
            @(posedge clk);
            hi = hi + int'(ck_pin_out);
        end
        chk(8'(hi), 8'h00);
    endtask
    task automatic t_cont();
        wr(ADDR_INTC, 8'h00);
        peer_u.pat = 16'hC33C;
        wr(ADDR_RXSC, 8'hB0);
        wait_bit(ADDR_INTC, 8'h02);
        chk({7'h00, rx_irq}, 8'h00);
        rchk(ADDR_RXBUF, 8'h3C);
        wait_bit(ADDR_INTC, 8'h02);
        rchk(ADDR_RXBUF, 8'hC3);
        wait_bit(ADDR_INTC, 8'h02);
        wait_bit(ADDR_RXSC, 8'h02);
        wr(ADDR_RXSC, 8'h80);
        rchk(ADDR_RXSC, 8'h80);
        rd(ADDR_RXBUF);
    endtask
    task automatic t_slave();
        wr(ADDR_TXSC, 8'h31);
        wr(ADDR_INTC, 8'h04);
        wr(ADDR_TXBUF, 8'h96);
        wr(ADDR_TXBUF, 8'h69);
        low_power <= 1'b1;
        rchk(ADDR_INTC, 8'h04);
        chk({6'h00, tx_irq, ck_pin_oe}, 8'h00);
        chk({7'h00, dt_pin_oe}, 8'h01);
        wr(ADDR_INTC, 8'h05);
        rchk(ADDR_INTC, 8'h04);
        peer_u.frame(8);
        chk(peer_u.got, 8'h96);
        repeat (4) @(posedge clk);
        rchk(ADDR_INTC, 8'h05);
        chk({7'h00, tx_irq}, 8'h01);
        peer_u.frame(8);
        chk(peer_u.got, 8'h69);
        repeat (4) @(posedge clk);
        rchk(ADDR_TXSC, 8'h33);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        resetn       = 1'b0;
        addr         = 3'h0;
        wr_data      = 8'h00;
        wr_en        = 1'b0;
        rd_en        = 1'b0;
        low_power    = 1'b0;
        error_cnt    = 0;
        total_checks = 0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_single();
        t_cont();
        t_slave();
        test_done();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done();
    end
endmodule
